/* File: bench/cdsc_host.sv */
// cdsc_host: host model handing whole 32-bit messages to the block
// assumes the reply comes with reply_valid one clock after the message is taken
`timescale 1ns/100ps
module cdsc_host
    import cdsc_pkg::*;
(
    input  wire logic        clk,
    output cdsc_msg_t        msg_data,
    output logic             msg_valid,
    input  wire logic        reply_valid,
    input  wire logic [31:0] reply_data
);
    initial begin
        msg_valid = 1'b0;
        msg_data  = '0;
    end

    task automatic send(input logic rw, input logic [3:0] id, input logic [2:0] ch, input logic [23:0] d,
                        output logic [31:0] got, output logic vld);
        @(posedge clk);
        msg_valid <= 1'b1;
        msg_data  <= {rw, id, ch, d};
        @(posedge clk);
        msg_valid <= 1'b0;
        // released word shows its inverse, never the last value
        msg_data  <= ~{rw, id, ch, d};
        #1;
        got = reply_data;
        vld = reply_valid;
    endtask
endmodule

/* File: bench/test_current_dither_setpoint_config.sv */
// test_current_dither_setpoint_config: message replies, enable hold and dither shape
// assumes the block on a 50 MHz clock, host model on the message port
`timescale 1ns/100ps
module test_current_dither_setpoint_config
    import cdsc_pkg::*;
();
    logic                       clk = 1'b0;
    logic                       rst_n;
    logic                       ce;
    logic                       enable_pin;
    logic                       msg_valid;
    logic                       reply_valid;
    logic                       vld;
    cdsc_msg_t                  msg_data;
    logic [13:0]                div_n;
    logic [1:0]                 div_m;
    logic [31:0]                reply_data;
    logic [31:0]                got;
    logic [7:0]                 channel_select_on;
    logic [7:0][CDSC_TGT_W-1:0] channel_select_target;
    logic [12:0]                t0;
    logic [12:0]                prev;
    logic [12:0]                lo;
    logic [12:0]                hi;
    int                         errors = 0;
    int                         tests_run = 0;
    int                         cycles = 0;
    int                         n;
    int                         i;

    always #10 clk = ~clk;

    cdsc_config_top i_cdsc_config_top (.clk(clk), .rst_n(rst_n), .ce(ce), .msg_valid(msg_valid),
        .msg_data(msg_data), .enable_pin(enable_pin), .div_n(div_n), .div_m(div_m),
        .reply_valid(reply_valid), .reply_data(reply_data), .channel_select_on(channel_select_on), .channel_select_target(channel_select_target));
    cdsc_host i_cdsc_host (.clk(clk), .msg_data(msg_data), .msg_valid(msg_valid),
        .reply_valid(reply_valid), .reply_data(reply_data));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            test_done();
        end
    end

    task automatic xfer(input logic rw, input logic [3:0] id, input logic [2:0] ch, input logic [23:0] d,
                        input logic [23:0] exp);
        i_cdsc_host.send(rw, id, ch, d, got, vld);
        check("reply_valid", {31'h0, vld}, 32'h1);
        check("reply_data", got, {1'b0, id, ch, exp});
    endtask

    // target of channel 5 must not move across several pwm periods
    task automatic steady(input logic [12:0] exp);
        repeat (3) begin
            repeat (40) @(posedge clk);
            #1;
            check("channel_select_target", {19'h0, channel_select_target[5]}, {19'h0, exp});
        end
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        enable_pin = 1'b0;
        div_n = 14'h0001;
        div_m = CDSC_M_32;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        xfer(1'b0, CDSC_ID_AMPL, 3'h0, 24'hFFFFFF, 24'h000000);
        xfer(1'b0, CDSC_ID_STEPS, 3'h7, 24'hFFFFFF, 24'h000000);
        xfer(1'b1, CDSC_ID_AMPL, 3'h3, 24'hFFFFFF, 24'hBFFFFF);
        xfer(1'b1, CDSC_ID_STEPS, 3'h3, 24'hFFFFFF, 24'h00001F);
        xfer(1'b0, CDSC_ID_AMPL, 3'h3, 24'h000000, 24'hBFFFFF);
        xfer(1'b1, CDSC_ID_AMPL, 3'h0, 24'h000100, 24'h000100);
        i_cdsc_host.send(1'b1, 4'h5, 3'h3, 24'h0, got, vld);
        check("no_reply", {31'h0, vld}, 32'h0);
        repeat (3) @(posedge clk);
        #1;
        check("channel_select_on", {24'h0, channel_select_on}, 32'h08);
        check("off_target", {19'h0, channel_select_target[0]}, 32'h0);
        @(posedge clk);
        enable_pin <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("channel_select_on", {24'h0, channel_select_on}, 32'hFF);
        @(posedge clk);
        enable_pin <= 1'b0;
        xfer(1'b1, CDSC_ID_AMPL, 3'h5, {2'b10, 11'h004, 11'h064}, {2'b10, 11'h004, 11'h064});
        steady(13'h0190);
        xfer(1'b1, CDSC_ID_AMPL, 3'h5, {2'b10, 11'h000, 11'h064}, {2'b10, 11'h000, 11'h064});
        xfer(1'b1, CDSC_ID_STEPS, 3'h5, 24'h000002, 24'h000002);
        steady(13'h0190);
        xfer(1'b1, CDSC_ID_AMPL, 3'h5, {2'b10, 11'h004, 11'h064}, {2'b10, 11'h004, 11'h064});
        t0 = channel_select_target[5];
        for (i = 0; i < 100 && channel_select_target[5] === t0; i++) begin
            @(posedge clk);
            #1;
        end
        t0 = channel_select_target[5];
        lo = t0;
        hi = t0;
        n = 0;
        for (i = 1; i <= 256; i++) begin
            prev = channel_select_target[5];
            @(posedge clk);
            #1;
            if (channel_select_target[5] !== prev) begin
                n++;
                check("tick_phase", 32'(i % 32), 32'h0);
            end
            lo = (channel_select_target[5] < lo) ? channel_select_target[5] : lo;
            hi = (channel_select_target[5] > hi) ? channel_select_target[5] : hi;
        end
        check("step_count", 32'(n), 32'h8);
        check("period", {19'h0, channel_select_target[5]}, {19'h0, t0});
        check("peak_peak", 32'(hi) - 32'(lo), 32'h10);
        check("centre", 32'(hi) + 32'(lo), 32'h320);
        // clock enable low: nothing moves and no message is taken
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        #1;
        t0 = channel_select_target[5];
        repeat (70) @(posedge clk);
        #1;
        check("ce_freeze", {19'h0, channel_select_target[5]}, {19'h0, t0});
        i_cdsc_host.send(1'b1, CDSC_ID_STEPS, 3'h5, 24'h000003, got, vld);
        check("ce_no_reply", {31'h0, vld}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        div_m <= CDSC_M_64;
        // skip two steps so the period counter settles on the new divider
        for (n = 0; n < 2; n++) begin
            t0 = channel_select_target[5];
            for (i = 0; i < 200 && channel_select_target[5] === t0; i++) begin
                @(posedge clk);
                #1;
            end
        end
        t0 = channel_select_target[5];
        for (i = 0; i < 200 && channel_select_target[5] === t0; i++) begin
            @(posedge clk);
            #1;
        end
        check("tick_gap_64", 32'(i), 32'h40);
        test_done();
    end
endmodule

/* File: rtl/cdsc_config_top.sv */
// cdsc_config_top: per-channel setpoint, dither and enable-hold configuration
// assumes msg_valid/msg_data come from a serial receiver on clk; enable_pin is asynchronous
// Behaviour
// - id 0011 addresses setpoint and dither amplitude
// - id 0100 addresses step count, bits 4:0
// - hold bit keeps channel running when disabled
// - step size bits 21:11, quarter setpoint unit
// - zero step or count gives no dither
// - step count per quarter, resets zero
// - dither period is four times count
// - peak-to-peak is twice step times count
// - setpoint bits 10:0, fraction of 2^11
// - amplitude reply echoes fields, bits 31,22 zero
// - step reply echoes count, bits 31,23:5 zero
// - pwm period is N times M clocks
// - bit 31 selects read or write
`timescale 1ns/100ps
module cdsc_config_top
    import cdsc_pkg::*;
#(
    parameter int NCH = 8
) (
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       msg_valid,
    input  wire cdsc_msg_t                  msg_data,
    input  wire logic                       enable_pin,
    input  wire logic [13:0]                div_n,
    input  wire logic [1:0]                 div_m,
    output logic                            reply_valid,
    output logic [31:0]                     reply_data,
    output logic [NCH-1:0]                  channel_select_on,
    output logic [NCH-1:0][CDSC_TGT_W-1:0]  channel_select_target
);
    typedef struct packed {
        logic                            en_s1;
        logic                            en_s2;
        cdsc_channel_select_cfg_t [NCH-1:0]        cfg;
        logic [13:0]                     ncnt;
        logic [8:0]                      mcnt;
        logic                            tick;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [NCH-1:0]                  on;
        logic [NCH-1:0][CDSC_TGT_W-1:0]  target;
    } cdsc_top_st_t;

    cdsc_top_st_t st_r;
    cdsc_top_st_t st_nxt;
    logic signed [NCH-1:0][17:0] offs;

    assign reply_valid = st_r.rvalid;
    assign reply_data  = st_r.rdata;
    assign channel_select_on     = st_r.on;
    assign channel_select_target = st_r.target;

    // setpoint in quarter units plus offset, held inside the 2^13 scale
    function automatic logic [CDSC_TGT_W-1:0] cdsc_sat(input logic [10:0] sp,
                                                       input logic signed [17:0] of);
        logic signed [19:0] sum;
        sum = signed'({7'h00, sp, 2'h0}) + 20'(of);
        if (sum < 0) begin
            cdsc_sat = '0;
        end else if (sum > 20'sd8191) begin
            cdsc_sat = '1;
        end else begin
            cdsc_sat = sum[CDSC_TGT_W-1:0];
        end
    endfunction

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        cdsc_dither u_dither (
            .clk    (clk),
            .rst_n  (rst_n),
            .ce     (ce),
            .run    (st_r.on[c]),
            .tick   (st_r.tick),
            .step   (st_r.cfg[c].step),
            .cnt    (st_r.cfg[c].cnt),
            .offset (offs[c])
        );
    end

    logic           is_ampl;
    logic           is_steps;
    logic [2:0]     ch;
    cdsc_channel_select_cfg_t cur;
    assign is_ampl  = msg_valid && msg_data.message_identifier == CDSC_ID_AMPL;
    assign is_steps = msg_valid && msg_data.message_identifier == CDSC_ID_STEPS;
    assign ch       = msg_data.channel_select;

    always_comb begin
        st_nxt       = st_r;
        st_nxt.en_s1 = enable_pin;
        st_nxt.en_s2 = st_r.en_s1;
        st_nxt.tick  = 1'b0;
        // pwm period: N clocks per sample, M samples per period
        if (st_r.ncnt + 14'h0001 >= div_n) begin
            st_nxt.ncnt = 14'h0000;
            if (st_r.mcnt + 9'h001 >= cdsc_m_count(div_m)) begin
                st_nxt.mcnt = 9'h000;
                st_nxt.tick = 1'b1;
            end else begin
                st_nxt.mcnt = st_r.mcnt + 9'h001;
            end
        end else begin
            st_nxt.ncnt = st_r.ncnt + 14'h0001;
        end
        // write fields only when bit 31 is set
        if (is_ampl && msg_data.rw) begin
            st_nxt.cfg[ch].hold = msg_data.data[CDSC_HOLD_POS];
            st_nxt.cfg[ch].step = msg_data.data[CDSC_STEP_LO +: CDSC_SET_W];
            st_nxt.cfg[ch].setp = msg_data.data[CDSC_SET_LO +: CDSC_SET_W];
        end
        if (is_steps && msg_data.rw) begin
            st_nxt.cfg[ch].cnt = msg_data.data[CDSC_CNT_LO +: CDSC_CNT_W];
        end
        // reply shows the contents after this message is applied
        cur           = st_nxt.cfg[ch];
        st_nxt.rvalid = is_ampl || is_steps;
        st_nxt.rdata  = '0;
        if (is_ampl) begin
            st_nxt.rdata = {1'b0, CDSC_ID_AMPL, ch, cur.hold, 1'b0, cur.step, cur.setp};
        end else if (is_steps) begin
            st_nxt.rdata = {1'b0, CDSC_ID_STEPS, ch, 19'h00000, cur.cnt};
        end
        for (int i = 0; i < NCH; i++) begin
            st_nxt.on[i]     = st_r.en_s2 || st_r.cfg[i].hold;
            st_nxt.target[i] = st_r.on[i] ? cdsc_sat(st_r.cfg[i].setp, offs[i]) : '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    reply_time_a: assert property (ce && (is_ampl || is_steps) |=> reply_valid)
        else $error("reply missing one cycle after message");
    ampl_reply_a: assert property (ce && is_ampl |=> reply_data[31] == 1'b0 && reply_data[22] == 1'b0
                                   && reply_data[30:27] == CDSC_ID_AMPL)
        else $error("amplitude reply header wrong");
    steps_reply_a: assert property (ce && is_steps |=> reply_data[31:27] == {1'b0, CDSC_ID_STEPS}
                                    && reply_data[23:5] == 19'h00000)
        else $error("step count reply not zero padded");
    ampl_write_a: assert property (ce && is_ampl && msg_data.rw
                                   |=> st_r.cfg[$past(ch)].setp == $past(msg_data.data[10:0]))
        else $error("setpoint not written");
    read_keep_a: assert property (ce && is_steps && !msg_data.rw
                                  |=> $stable(st_r.cfg))
        else $error("read changed the configuration");
    hold_off_a: assert property (ce && !st_r.en_s2 && !st_r.cfg[0].hold
                                 |=> !channel_select_on[0] ##1 channel_select_target[0] == '0 || !ce)
        else $error("channel running while disabled without hold");
    tick_gap_a: assert property (st_r.tick |-> st_r.ncnt == 14'h0000 && st_r.mcnt == 9'h000)
        else $error("pwm tick off the period boundary");

    ampl_write_c: cover property (ce && is_ampl && msg_data.rw);
    steps_read_c: cover property (ce && is_steps && !msg_data.rw);
    hold_run_c:   cover property (!st_r.en_s2 && channel_select_on[0]);
endmodule

/* File: rtl/cdsc_dither.sv */
// cdsc_dither: triangular dither offset for one channel, in quarter setpoint units
// assumes tick is a one-cycle pulse per pwm period from the same clock
`timescale 1ns/100ps
module cdsc_dither
    import cdsc_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic               run,
    input  wire logic               tick,
    input  wire logic [10:0]        step,
    input  wire logic [4:0]         cnt,
    output logic signed [17:0]      offset
);
    cdsc_dither_st_t st_r;
    cdsc_dither_st_t st_nxt;
    logic signed [17:0] step_s;

    assign step_s = signed'({7'h00, step});
    assign offset = st_r.offs;

    always_comb begin
        st_nxt = st_r;
        if (!run || step == 11'h000 || cnt == 5'h00) begin
            st_nxt = '0;
        end else if (tick) begin
            case (st_r.quad)
                CDSC_Q_RISE, CDSC_Q_RISE_NEG: st_nxt.offs = st_r.offs + step_s;
                default:                      st_nxt.offs = st_r.offs - step_s;
            endcase
            // four runs of cnt steps make one period
            if (st_r.idx >= cnt - 5'h01) begin
                st_nxt.idx  = 5'h00;
                st_nxt.quad = cdsc_quad_t'(st_r.quad + 2'h1);
            end else begin
                st_nxt.idx = st_r.idx + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    no_dither_a: assert property (ce && (step == 11'h000 || cnt == 5'h00) |=> offset == 18'sd0)
        else $error("dither present with zero step or count");
    ramp_step_a: assert property (ce && run && tick && step != 11'h000 && cnt != 5'h00
                                  && st_r.quad == CDSC_Q_RISE ##1 run
                                  |-> offset == $past(offset) + $past(step_s))
        else $error("rising dither did not move by one step");
    offs_bound_a: assert property (offset <= 18'sd63457 && offset >= -18'sd63457)
        else $error("dither offset outside amplitude");
endmodule

/* File: rtl/cdsc_pkg.sv */
// cdsc_pkg: message layout, reset values and types for the dither setpoint block
// assumes messages arrive already framed as 32-bit words on the main clock
package cdsc_pkg;
    localparam logic [3:0]  CDSC_ID_AMPL   = 4'h3;
    localparam logic [3:0]  CDSC_ID_STEPS  = 4'h4;
    localparam int          CDSC_HOLD_POS  = 23;
    localparam int          CDSC_STEP_LO   = 11;
    localparam int          CDSC_SET_LO    = 0;
    localparam int          CDSC_CNT_LO    = 0;
    localparam int          CDSC_SET_W     = 11;
    localparam int          CDSC_CNT_W     = 5;
    localparam int          CDSC_TGT_W     = 13;
    localparam int          CDSC_OFS_W     = 18;
    localparam int          CDSC_QSHIFT    = 2;
    localparam logic        CDSC_HOLD_RST  = 1'b0;
    localparam logic [10:0] CDSC_STEP_RST  = 11'h000;
    localparam logic [10:0] CDSC_SET_RST   = 11'h000;
    localparam logic [4:0]  CDSC_CNT_RST   = 5'h00;
    localparam logic [13:0] CDSC_DIVN_RST  = 14'h271;
    localparam logic [1:0]  CDSC_M_32      = 2'h0;
    localparam logic [1:0]  CDSC_M_64      = 2'h1;
    localparam logic [8:0]  CDSC_MCNT_32   = 9'h020;
    localparam logic [8:0]  CDSC_MCNT_64   = 9'h040;
    localparam logic [8:0]  CDSC_MCNT_128  = 9'h080;

    typedef struct packed {
        logic        rw;
        logic [3:0]  message_identifier;
        logic [2:0]  channel_select;
        logic [23:0] data;
    } cdsc_msg_t;

    typedef struct packed {
        logic        hold;
        logic [10:0] step;
        logic [10:0] setp;
        logic [4:0]  cnt;
    } cdsc_channel_select_cfg_t;

    typedef enum logic [1:0] {
        CDSC_Q_RISE, CDSC_Q_FALL, CDSC_Q_FALL_NEG, CDSC_Q_RISE_NEG
    } cdsc_quad_t;

    typedef struct packed {
        logic signed [17:0] offs;
        logic [4:0]         idx;
        cdsc_quad_t         quad;
    } cdsc_dither_st_t;

    // samples per pwm period; the 512 code behaves as 128 in current control
    function automatic logic [8:0] cdsc_m_count(input logic [1:0] code);
        case (code)
            CDSC_M_32: cdsc_m_count = CDSC_MCNT_32;
            CDSC_M_64: cdsc_m_count = CDSC_MCNT_64;
            default:   cdsc_m_count = CDSC_MCNT_128;
        endcase
    endfunction
endpackage
